// >>> logic/bsbx_core.sv
// Purpose: Executes all-ones load, pointer jump/call, compares, skips,
//          flag branches, I/O bit force and shifts of an 8-bit core.
// Assumes: Software loads instruction words over the register port, then
//          writes the go bit; results sit in the register file.
// Notes:   Effects land at the first edge; later cycles only hold busy.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module bsbx_core import bsbx_pkg::*; (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic busy
);
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [7:0] gpr_reg [32];
    logic [7:0] gpr_next [32];
    logic [7:0] io_reg [32];
    logic [7:0] io_next [32];
    logic [7:0] processor_status_flags_reg, processor_status_flags_next;
    logic [15:0] pc_reg, pc_next, sp_reg, sp_next, ret_reg, ret_next;
    logic [15:0] instr_reg, instr_next, nxt_reg, nxt_next;
    logic [1:0] cnt_reg, cnt_next, cyc_reg, cyc_next;
    logic bad_reg, bad_next, busy_reg, busy_next;
    logic [7:0] rdata_reg, rdata_next, rd_mux;

    // Decode
    logic go, is_cpi, next_long, flag_val, bit_val, cmp_c;
    logic [4:0] op, fd, fr;
    logic [2:0] bsel;
    logic [7:0] opa, opb, opio, cmp_b, mask, cmp_r;
    logic [8:0] diff;
    logic [15:0] z_ptr, k_ext, skip_adv;
    logic [1:0] skip_cyc;

    // Reset is released through two flops so removal is clean
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    assign go = bus_wr && (bus_addr == ADDR_CTRL) && bus_wdata[CTRL_GO_BIT] && (cnt_reg == 2'h0);
    assign is_cpi = (instr_reg[15:12] == OP_COMPARE_IMMEDIATE);
    assign op = instr_reg[15:11];
    assign fd = is_cpi ? {1'b1, instr_reg[11:8]} : instr_reg[10:6];
    assign fr = instr_reg[4:0];
    assign bsel = instr_reg[2:0];
    assign opa = gpr_reg[fd];
    assign opb = gpr_reg[fr];
    assign opio = io_reg[fd];
    assign mask = 8'h01 << bsel;
    assign z_ptr = {gpr_reg[31], gpr_reg[30]};
    assign k_ext = {{9{instr_reg[6]}}, instr_reg[6:0]};
    assign next_long = (nxt_reg[15:11] == OP_LONG_PREFIX);
    assign skip_adv = next_long ? SKIP_LONG_ADV : SKIP_SHORT_ADV;
    assign skip_cyc = next_long ? CYC_SKIP_LONG : CYC_SKIP_SHORT;
    // Signed select reads N xor V live, never a stale sign flag
    assign flag_val = (instr_reg[10:8] == FLAG_S) ? (processor_status_flags_reg[FLAG_N] ^ processor_status_flags_reg[FLAG_V])
                                                  : processor_status_flags_reg[instr_reg[10:8]];
    assign bit_val = (op == OP_SKIP_IO_BIT_CLEAR || op == OP_SKIP_IO_BIT_SET) ?
                     opio[bsel] : opb[bsel];
    assign cmp_b = is_cpi ? instr_reg[7:0] : opb;
    assign cmp_c = (op == OP_COMPARE_WITH_CARRY) && !is_cpi && processor_status_flags_reg[FLAG_C];
    assign diff = {1'b0, opa} - {1'b0, cmp_b} - {8'h00, cmp_c};
    assign cmp_r = diff[7:0];

    always_comb begin
        rd_mux = 8'h00;
        if (bus_addr < ADDR_IO_BASE) begin
            rd_mux = gpr_reg[bus_addr[4:0]];
        end else if (bus_addr < ADDR_PROCESSOR_STATUS_FLAGS) begin
            rd_mux = io_reg[bus_addr[4:0]];
        end else begin
            case (bus_addr)
                ADDR_PROCESSOR_STATUS_FLAGS: rd_mux = processor_status_flags_reg;
                ADDR_PC_LO: rd_mux = pc_reg[7:0];
                ADDR_PC_HI: rd_mux = pc_reg[15:8];
                ADDR_INSTR_LO: rd_mux = instr_reg[7:0];
                ADDR_INSTR_HI: rd_mux = instr_reg[15:8];
                ADDR_NEXT_LO: rd_mux = nxt_reg[7:0];
                ADDR_NEXT_HI: rd_mux = nxt_reg[15:8];
                ADDR_CTRL: rd_mux = {6'h00, bad_reg, busy_reg};
                ADDR_CYCLES: rd_mux = {6'h00, cyc_reg};
                ADDR_SP_LO: rd_mux = sp_reg[7:0];
                ADDR_SP_HI: rd_mux = sp_reg[15:8];
                ADDR_RET_LO: rd_mux = ret_reg[7:0];
                ADDR_RET_HI: rd_mux = ret_reg[15:8];
                default: rd_mux = 8'h00;
            endcase
        end
    end

    always_comb begin
        gpr_next = gpr_reg;
        io_next = io_reg;
        processor_status_flags_next = processor_status_flags_reg;
        pc_next = pc_reg;
        sp_next = sp_reg;
        ret_next = ret_reg;
        instr_next = instr_reg;
        nxt_next = nxt_reg;
        cyc_next = cyc_reg;
        bad_next = bad_reg;
        cnt_next = (cnt_reg != 2'h0) ? cnt_reg - 2'h1 : 2'h0;
        rdata_next = bus_rd ? rd_mux : 8'h00;
        if (bus_wr) begin
            if (bus_addr < ADDR_IO_BASE) begin
                gpr_next[bus_addr[4:0]] = bus_wdata;
            end else if (bus_addr < ADDR_PROCESSOR_STATUS_FLAGS) begin
                io_next[bus_addr[4:0]] = bus_wdata;
            end else begin
                case (bus_addr)
                    ADDR_PROCESSOR_STATUS_FLAGS: processor_status_flags_next = bus_wdata;
                    ADDR_PC_LO: pc_next[7:0] = bus_wdata;
                    ADDR_PC_HI: pc_next[15:8] = bus_wdata;
                    ADDR_INSTR_LO: instr_next[7:0] = bus_wdata;
                    ADDR_INSTR_HI: instr_next[15:8] = bus_wdata;
                    ADDR_NEXT_LO: nxt_next[7:0] = bus_wdata;
                    ADDR_NEXT_HI: nxt_next[15:8] = bus_wdata;
                    ADDR_SP_LO: sp_next[7:0] = bus_wdata;
                    ADDR_SP_HI: sp_next[15:8] = bus_wdata;
                    default: ;
                endcase
            end
        end
        if (go) begin
            pc_next = pc_reg + 16'h0001;
            cyc_next = CYC_ONE;
            bad_next = 1'b0;
            if (is_cpi) begin
                processor_status_flags_next[FLAG_Z] = (cmp_r == 8'h00);
            end else begin
                case (op)
                    OP_LOAD_ALL_ONES: gpr_next[fd] = 8'hFF;
                    OP_POINTER_JUMP: begin
                        pc_next = z_ptr;
                        cyc_next = CYC_JUMP;
                    end
                    OP_POINTER_CALL: begin
                        ret_next = pc_reg + 16'h0001;
                        sp_next = sp_reg - RET_PUSH_BYTES;
                        pc_next = z_ptr;
                        cyc_next = CYC_CALL;
                    end
                    OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
                    OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
                        if ((op == OP_COMPARE_SKIP_EQUAL && opa == opb) ||
                            (op == OP_SKIP_REG_BIT_CLEAR && !bit_val) ||
                            (op == OP_SKIP_REG_BIT_SET && bit_val) ||
                            (op == OP_SKIP_IO_BIT_CLEAR && !bit_val) ||
                            (op == OP_SKIP_IO_BIT_SET && bit_val)) begin
                            pc_next = pc_reg + skip_adv;
                            cyc_next = skip_cyc;
                        end
                    end
                    OP_COMPARE, OP_COMPARE_WITH_CARRY: begin
                        // With carry, zero only survives if it was already set
                        processor_status_flags_next[FLAG_Z] = (cmp_r == 8'h00) &&
                            (op == OP_COMPARE || processor_status_flags_reg[FLAG_Z]);
                    end
                    // Unsigned, signed, named and interrupt branches are selects of s
                    OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR: begin
                        if (flag_val == (op == OP_BRANCH_FLAG_SET)) begin
                            pc_next = pc_reg + k_ext + 16'h0001;
                            cyc_next = CYC_BRANCH_TAKEN;
                        end
                    end
                    OP_IO_BIT_FORCE_ONE: begin
                        io_next[fd] = opio | mask;
                        cyc_next = CYC_IO_BIT;
                    end
                    OP_IO_BIT_FORCE_ZERO: begin
                        io_next[fd] = opio & ~mask;
                        cyc_next = CYC_IO_BIT;
                    end
                    OP_SHIFT_LEFT_LOGICAL: gpr_next[fd] = {opa[6:0], 1'b0};
                    OP_SHIFT_RIGHT_LOGICAL: gpr_next[fd] = {1'b0, opa[7:1]};
                    OP_ROTATE_LEFT_CARRY: gpr_next[fd] = {opa[6:0], processor_status_flags_reg[FLAG_C]};
                    default: bad_next = 1'b1;
                endcase
            end
            if (is_cpi || op == OP_COMPARE || op == OP_COMPARE_WITH_CARRY) begin
                processor_status_flags_next[FLAG_N] = cmp_r[7];
                processor_status_flags_next[FLAG_V] = (opa[7] & ~cmp_b[7] & ~cmp_r[7]) | (~opa[7] & cmp_b[7] & cmp_r[7]);
                processor_status_flags_next[FLAG_C] = diff[8];
                processor_status_flags_next[FLAG_H] = (~opa[3] & cmp_b[3]) | (cmp_b[3] & cmp_r[3]) | (cmp_r[3] & ~opa[3]);
                processor_status_flags_next[FLAG_S] = processor_status_flags_next[FLAG_N] ^ processor_status_flags_next[FLAG_V];
            end else if (op == OP_SHIFT_LEFT_LOGICAL || op == OP_SHIFT_RIGHT_LOGICAL ||
                         op == OP_ROTATE_LEFT_CARRY) begin
                processor_status_flags_next[FLAG_Z] = (gpr_next[fd] == 8'h00);
                processor_status_flags_next[FLAG_C] = (op == OP_SHIFT_RIGHT_LOGICAL) ? opa[0] : opa[7];
                processor_status_flags_next[FLAG_N] = gpr_next[fd][7];
                processor_status_flags_next[FLAG_V] = processor_status_flags_next[FLAG_N] ^ processor_status_flags_next[FLAG_C];
                processor_status_flags_next[FLAG_S] = processor_status_flags_next[FLAG_N] ^ processor_status_flags_next[FLAG_V];
            end
            cnt_next = cyc_next;
        end
        busy_next = (cnt_next != 2'h0);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) begin
                gpr_reg[i] <= 8'h00;
                io_reg[i] <= 8'h00;
            end
            processor_status_flags_reg <= PROCESSOR_STATUS_FLAGS_RESET;
            pc_reg <= PC_RESET;
            sp_reg <= SP_RESET;
            ret_reg <= PC_RESET;
            instr_reg <= 16'h0000;
            nxt_reg <= 16'h0000;
            cnt_reg <= 2'h0;
            cyc_reg <= 2'h0;
            bad_reg <= 1'b0;
            busy_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            gpr_reg <= gpr_next;
            io_reg <= io_next;
            processor_status_flags_reg <= processor_status_flags_next;
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            ret_reg <= ret_next;
            instr_reg <= instr_next;
            nxt_reg <= nxt_next;
            cnt_reg <= cnt_next;
            cyc_reg <= cyc_next;
            bad_reg <= bad_next;
            busy_reg <= busy_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bus_rdata = rdata_reg;
    assign busy = busy_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_ones_no_flags: assert property (go && !is_cpi && op == OP_LOAD_ALL_ONES |=>
        gpr_reg[$past(fd)] == 8'hFF && processor_status_flags_reg == $past(processor_status_flags_reg) && busy ##1 !busy)
        else $error("all-ones load wrong");
    a_jump_from_z: assert property (go && !is_cpi && op == OP_POINTER_JUMP |=>
        pc_reg == $past(z_ptr) && busy[*2] ##1 !busy)
        else $error("pointer jump wrong");
    a_call_push_z: assert property (go && !is_cpi && op == OP_POINTER_CALL |=>
        pc_reg == $past(z_ptr) && ret_reg == $past(pc_reg) + 16'h0001 &&
        sp_reg == $past(sp_reg) - 16'h0002 && busy ##1 busy ##1 busy ##1 !busy)
        else $error("pointer call wrong");
    a_skip_equal_adv: assert property (go && !is_cpi && op == OP_COMPARE_SKIP_EQUAL &&
        opa == opb |=> pc_reg == $past(pc_reg) + ($past(next_long) ? 16'h0003 : 16'h0002) &&
        cyc_reg == ($past(next_long) ? 2'h3 : 2'h2))
        else $error("equal skip wrong");
    a_compare_keeps_reg: assert property (go && (is_cpi || op == OP_COMPARE) |=>
        gpr_reg[$past(fd)] == $past(opa) && processor_status_flags_reg[0] == ($past(opa) < $past(cmp_b)))
        else $error("compare wrong");
    a_noskip_one_cycle: assert property (go && !is_cpi && op == OP_SKIP_REG_BIT_SET &&
        !bit_val |=> pc_reg == $past(pc_reg) + 16'h0001 && processor_status_flags_reg == $past(processor_status_flags_reg)
        ##1 !busy)
        else $error("register bit skip wrong");
    a_branch_target: assert property (go && !is_cpi && op == OP_BRANCH_FLAG_SET && flag_val |=>
        pc_reg == $past(pc_reg) + $past(k_ext) + 16'h0001 && busy ##1 busy ##1 !busy)
        else $error("taken branch wrong");
    a_io_force_one: assert property (go && !is_cpi && op == OP_IO_BIT_FORCE_ONE |=>
        io_reg[$past(fd)] == ($past(opio) | $past(mask)) && processor_status_flags_reg == $past(processor_status_flags_reg))
        else $error("io bit force one wrong");
    a_io_force_zero: assert property (go && !is_cpi && op == OP_IO_BIT_FORCE_ZERO |=>
        io_reg[$past(fd)] == ($past(opio) & ~$past(mask)) && busy ##1 busy ##1 !busy)
        else $error("io bit force zero wrong");
    a_rotate_carry_in: assert property (go && !is_cpi && op == OP_ROTATE_LEFT_CARRY |=>
        gpr_reg[$past(fd)] == {$past(opa[6:0]), $past(processor_status_flags_reg[0])} &&
        processor_status_flags_reg[0] == $past(opa[7]))
        else $error("rotate through carry wrong");
    a_shift_left_res: assert property (go && !is_cpi && op == OP_SHIFT_LEFT_LOGICAL |=>
        gpr_reg[$past(fd)] == {$past(opa[6:0]), 1'b0} && processor_status_flags_reg[0] == $past(opa[7]))
        else $error("left shift wrong");
endmodule // bsbx_core
`default_nettype wire

// >>> pkg/bsbx_pkg.sv
// Purpose: Constants shared by the branch, skip and bit execution core.
// Assumes: 8-bit register port, 16-bit instruction words.
// Notes:   Opcode values are local to this core.
`default_nettype none
package bsbx_pkg;
    // Register port map
    localparam logic [7:0] ADDR_IO_BASE  = 8'h20;
    localparam logic [7:0] ADDR_PROCESSOR_STATUS_FLAGS     = 8'h40;
    localparam logic [7:0] ADDR_PC_LO    = 8'h41;
    localparam logic [7:0] ADDR_PC_HI    = 8'h42;
    localparam logic [7:0] ADDR_INSTR_LO = 8'h43;
    localparam logic [7:0] ADDR_INSTR_HI = 8'h44;
    localparam logic [7:0] ADDR_NEXT_LO  = 8'h45;
    localparam logic [7:0] ADDR_NEXT_HI  = 8'h46;
    localparam logic [7:0] ADDR_CTRL     = 8'h47;
    localparam logic [7:0] ADDR_CYCLES   = 8'h48;
    localparam logic [7:0] ADDR_SP_LO    = 8'h49;
    localparam logic [7:0] ADDR_SP_HI    = 8'h4A;
    localparam logic [7:0] ADDR_RET_LO   = 8'h4B;
    localparam logic [7:0] ADDR_RET_HI   = 8'h4C;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_BUSY_BIT = 0;
    localparam int CTRL_BAD_BIT = 1;
    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [7:0] PROCESSOR_STATUS_FLAGS_RESET = 8'h00;
    // Status flag positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;
    // Opcodes in bits 15:11; compare_immediate owns every word with 15:12 = F
    localparam logic [4:0] OP_LOAD_ALL_ONES = 5'h01;
    localparam logic [4:0] OP_POINTER_JUMP = 5'h02;
    localparam logic [4:0] OP_POINTER_CALL = 5'h03;
    localparam logic [4:0] OP_COMPARE_SKIP_EQUAL = 5'h04;
    localparam logic [4:0] OP_COMPARE = 5'h05;
    localparam logic [4:0] OP_COMPARE_WITH_CARRY = 5'h06;
    localparam logic [4:0] OP_SKIP_REG_BIT_CLEAR = 5'h07;
    localparam logic [4:0] OP_SKIP_REG_BIT_SET = 5'h08;
    localparam logic [4:0] OP_SKIP_IO_BIT_CLEAR = 5'h09;
    localparam logic [4:0] OP_SKIP_IO_BIT_SET = 5'h0A;
    localparam logic [4:0] OP_BRANCH_FLAG_SET = 5'h0B;
    localparam logic [4:0] OP_BRANCH_FLAG_CLEAR = 5'h0C;
    localparam logic [4:0] OP_IO_BIT_FORCE_ONE = 5'h0D;
    localparam logic [4:0] OP_IO_BIT_FORCE_ZERO = 5'h0E;
    localparam logic [4:0] OP_SHIFT_LEFT_LOGICAL = 5'h0F;
    localparam logic [4:0] OP_SHIFT_RIGHT_LOGICAL = 5'h10;
    localparam logic [4:0] OP_ROTATE_LEFT_CARRY = 5'h11;
    localparam logic [4:0] OP_LONG_PREFIX = 5'h1D;
    localparam logic [3:0] OP_COMPARE_IMMEDIATE = 4'hF;
    // Cycle counts, skip advances and call push bytes
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_JUMP = 2'h2;
    localparam logic [1:0] CYC_CALL = 2'h3;
    localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
    localparam logic [1:0] CYC_IO_BIT = 2'h2;
    localparam logic [1:0] CYC_SKIP_SHORT = 2'h2;
    localparam logic [1:0] CYC_SKIP_LONG = 2'h3;
    localparam logic [15:0] SKIP_SHORT_ADV = 16'h0002;
    localparam logic [15:0] SKIP_LONG_ADV = 16'h0003;
    localparam logic [15:0] RET_PUSH_BYTES = 16'h0002;
endpackage
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the branch, skip and bit execution core.
// Assumes: Register port map, encodings and cycle counts from bsbx_pkg.
// Notes:   Every exec instruction runs from PC 0x0010; S flag is masked on compares.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import bsbx_pkg::*;
    logic ref_clk, resetn, bus_wr, bus_rd, busy;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    int n_errors, tests_run, cyc;

    bsbx_core uut (.ref_clk(ref_clk), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .busy(busy));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] mk(input logic [4:0] op, input logic [4:0] d,
        input logic [4:0] r);
        return {op, d, 1'b0, r};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic chk(input string nm, input logic [7:0] a, input logic [7:0] exp,
        input logic [7:0] mask = 8'hFF);
        logic [7:0] d;
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        @(negedge ref_clk);
        d = bus_rdata;
        tests_run++;
        if ((d & mask) !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, d);
        end
    endtask

    // Busy length is the cycle count, so it is measured as well as read back
    task automatic exec(input logic [15:0] ins, input logic [15:0] nxt, input int ncyc,
        input logic [15:0] pc);
        int n;
        n = 0;
        wr(ADDR_PC_LO, 8'h10);
        wr(ADDR_PC_HI, 8'h00);
        wr(ADDR_INSTR_LO, ins[7:0]);
        wr(ADDR_INSTR_HI, ins[15:8]);
        wr(ADDR_NEXT_LO, nxt[7:0]);
        wr(ADDR_NEXT_HI, nxt[15:8]);
        wr(ADDR_CTRL, 8'h01);
        for (int i = 0; i < 20; i++) begin
            @(negedge ref_clk);
            if (busy !== 1'b1) break;
            n++;
        end
        tests_run++;
        if (n != ncyc) begin
            n_errors++;
            $display("Error busy cycles of %h expected %0d seen %0d", ins, ncyc, n);
        end
        chk("cycles", ADDR_CYCLES, 8'(ncyc));
        chk("pc low", ADDR_PC_LO, pc[7:0]);
        chk("pc high", ADDR_PC_HI, pc[15:8]);
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Whole run is near 1400 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            $display("Error timeout expected end seen hang");
            close_out();
        end
    end

    initial begin
        logic [7:0] fl;
        logic [2:0] sl;
        resetn = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        n_errors = 0;
        tests_run = 0;
        cyc = 0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("sp low", ADDR_SP_LO, SP_RESET[7:0]);
        chk("sp high", ADDR_SP_HI, SP_RESET[15:8]);
        chk("status", ADDR_PROCESSOR_STATUS_FLAGS, PROCESSOR_STATUS_FLAGS_RESET);
        chk("unmapped", 8'h80, 8'h00);
        $display("test reset done");
        wr(8'h07, 8'h12);
        wr(ADDR_PROCESSOR_STATUS_FLAGS, 8'h5A);
        exec(mk(OP_LOAD_ALL_ONES, 5'd7, 5'd0), 16'h0000, 1, 16'h0011);
        chk("r7", 8'h07, 8'hFF);
        wr(8'h1E, 8'h34);
        wr(8'h1F, 8'h12);
        exec(mk(OP_POINTER_JUMP, 5'd0, 5'd0), 16'h0000, 2, 16'h1234);
        exec(mk(OP_POINTER_CALL, 5'd0, 5'd0), 16'h0000, 3, 16'h1234);
        chk("ret low", ADDR_RET_LO, 8'h11);
        chk("ret high", ADDR_RET_HI, 8'h00);
        chk("sp low", ADDR_SP_LO, 8'hFD);
        chk("status", ADDR_PROCESSOR_STATUS_FLAGS, 8'h5A);
        // Second go inside the busy window must be dropped
        wr(ADDR_PC_LO, 8'h10);
        wr(ADDR_INSTR_LO, 8'h00);
        wr(ADDR_INSTR_HI, 8'h18);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        repeat (4) @(posedge ref_clk);
        chk("ret low", ADDR_RET_LO, 8'h11);
        chk("sp low", ADDR_SP_LO, 8'hFB);
        $display("test load and pointer done");
        wr(8'h01, 8'h33);
        wr(8'h02, 8'h33);
        exec(mk(OP_COMPARE_SKIP_EQUAL, 5'd1, 5'd2), 16'h0000, 2, 16'h0012);
        exec(mk(OP_COMPARE_SKIP_EQUAL, 5'd1, 5'd2), 16'hE800, 3, 16'h0013);
        wr(8'h02, 8'h34);
        exec(mk(OP_COMPARE_SKIP_EQUAL, 5'd1, 5'd2), 16'hE800, 1, 16'h0011);
        chk("r1", 8'h01, 8'h33);
        chk("status", ADDR_PROCESSOR_STATUS_FLAGS, 8'h5A);
        for (int i = 0; i < 2; i++) begin
            wr(8'h05, i ? 8'h20 : 8'hDF);
            wr(8'h23, i ? 8'h08 : 8'hF7);
            exec(mk(OP_SKIP_REG_BIT_SET, 5'd5, 5'd5), 16'h0000, i ? 2 : 1, i ? 16'h12 : 16'h11);
            exec(mk(OP_SKIP_REG_BIT_CLEAR, 5'd5, 5'd5), 16'hE800, i ? 1 : 3, i ? 16'h11 : 16'h13);
            exec(mk(OP_SKIP_IO_BIT_SET, 5'd3, 5'd3), 16'hE800, i ? 3 : 1, i ? 16'h13 : 16'h11);
            exec(mk(OP_SKIP_IO_BIT_CLEAR, 5'd3, 5'd3), 16'h0000, i ? 1 : 2, i ? 16'h11 : 16'h12);
        end
        chk("status", ADDR_PROCESSOR_STATUS_FLAGS, 8'h5A);
        $display("test skips done");
        wr(8'h01, 8'h10);
        wr(8'h02, 8'h20);
        wr(ADDR_PROCESSOR_STATUS_FLAGS, 8'h00);
        exec(mk(OP_COMPARE, 5'd1, 5'd2), 16'h0000, 1, 16'h0011);
        chk("compare flags", ADDR_PROCESSOR_STATUS_FLAGS, 8'h05, 8'hEF);
        chk("r1", 8'h01, 8'h10);
        wr(8'h10, 8'h80);
        exec(16'hF001, 16'h0000, 1, 16'h0011);
        chk("immediate flags", ADDR_PROCESSOR_STATUS_FLAGS, 8'h28, 8'hEF);
        chk("r16", 8'h10, 8'h80);
        wr(8'h02, 8'h10);
        wr(ADDR_PROCESSOR_STATUS_FLAGS, 8'h03);
        exec(mk(OP_COMPARE_WITH_CARRY, 5'd1, 5'd2), 16'h0000, 1, 16'h0011);
        chk("carry compare flags", ADDR_PROCESSOR_STATUS_FLAGS, 8'h25, 8'hEF);
        wr(ADDR_PROCESSOR_STATUS_FLAGS, 8'h00);
        exec(mk(OP_COMPARE_WITH_CARRY, 5'd1, 5'd2), 16'h0000, 1, 16'h0011);
        chk("zero chaining", ADDR_PROCESSOR_STATUS_FLAGS, 8'h00, 8'hEF);
        wr(ADDR_PROCESSOR_STATUS_FLAGS, 8'h02);
        exec(mk(OP_COMPARE_WITH_CARRY, 5'd1, 5'd2), 16'h0000, 1, 16'h0011);
        chk("zero kept", ADDR_PROCESSOR_STATUS_FLAGS, 8'h02, 8'hEF);
        $display("test compares done");
        for (int s = 0; s < 8; s++) begin
            sl = s[2:0];
            fl = (s == 4) ? 8'h04 : (8'h01 << s);
            wr(ADDR_PROCESSOR_STATUS_FLAGS, fl);
            exec({OP_BRANCH_FLAG_SET, sl, 8'h7D}, 16'h0000, 2, 16'h000E);
            exec({OP_BRANCH_FLAG_CLEAR, sl, 8'h05}, 16'h0000, 1, 16'h0011);
            chk("flags kept", ADDR_PROCESSOR_STATUS_FLAGS, fl);
            wr(ADDR_PROCESSOR_STATUS_FLAGS, (s == 4) ? 8'h0C : 8'h00);
            exec({OP_BRANCH_FLAG_SET, sl, 8'h7D}, 16'h0000, 1, 16'h0011);
            exec({OP_BRANCH_FLAG_CLEAR, sl, 8'h05}, 16'h0000, 2, 16'h0016);
        end
        $display("test branches done");
        wr(8'h22, 8'hA5);
        wr(ADDR_PROCESSOR_STATUS_FLAGS, 8'h5A);
        exec(mk(OP_IO_BIT_FORCE_ONE, 5'd2, 5'd1), 16'h0000, 2, 16'h0011);
        chk("io2 set", 8'h22, 8'hA7);
        exec(mk(OP_IO_BIT_FORCE_ZERO, 5'd2, 5'd0), 16'h0000, 2, 16'h0011);
        chk("io2 clear", 8'h22, 8'hA6);
        chk("status", ADDR_PROCESSOR_STATUS_FLAGS, 8'h5A);
        $display("test io bits done");
        wr(8'h04, 8'h81);
        wr(ADDR_PROCESSOR_STATUS_FLAGS, 8'h20);
        exec(mk(OP_SHIFT_LEFT_LOGICAL, 5'd4, 5'd0), 16'h0000, 1, 16'h0011);
        chk("shl value", 8'h04, 8'h02);
        chk("shl flags", ADDR_PROCESSOR_STATUS_FLAGS, 8'h29, 8'hEF);
        wr(8'h04, 8'h01);
        wr(ADDR_PROCESSOR_STATUS_FLAGS, 8'h20);
        exec(mk(OP_SHIFT_RIGHT_LOGICAL, 5'd4, 5'd0), 16'h0000, 1, 16'h0011);
        chk("shr value", 8'h04, 8'h00);
        chk("shr flags", ADDR_PROCESSOR_STATUS_FLAGS, 8'h2B, 8'hEF);
        wr(8'h04, 8'h80);
        wr(ADDR_PROCESSOR_STATUS_FLAGS, 8'h21);
        exec(mk(OP_ROTATE_LEFT_CARRY, 5'd4, 5'd0), 16'h0000, 1, 16'h0011);
        chk("rol value", 8'h04, 8'h01);
        chk("rol flags", ADDR_PROCESSOR_STATUS_FLAGS, 8'h29, 8'hEF);
        $display("test shifts done");
        exec(mk(5'h12, 5'd0, 5'd0), 16'h0000, 1, 16'h0011);
        chk("bad opcode", ADDR_CTRL, 8'h02, 8'h03);
        $display("test unknown opcode done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
